//--- core/dtc_pkg.sv
package dtc_pkg;

	// ****************************************
	// Register offsets on the special function register bus
	// ****************************************
	localparam logic [7:0] TIMER_CONTROL_FLAGS_ADDR = 8'h88;
	localparam logic [7:0] TIMER_MODE_SELECT_ADDR = 8'h89;
	localparam logic [7:0] FIRST_COUNT_LOW_ADDR = 8'h8A;
	localparam logic [7:0] SECOND_COUNT_LOW_ADDR = 8'h8B;
	localparam logic [7:0] FIRST_COUNT_HIGH_ADDR = 8'h8C;
	localparam logic [7:0] SECOND_COUNT_HIGH_ADDR = 8'h8D;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;

	// ****************************************
	// Field positions in timer_control_flags
	// ****************************************
	localparam int SECOND_OVERFLOW_FLAG_POS = 7;
	localparam int SECOND_RUN_BIT_POS = 6;
	localparam int FIRST_OVERFLOW_FLAG_POS = 5;
	localparam int FIRST_RUN_BIT_POS = 4;
	localparam int EXT_IRQ_B_EDGE_FLAG_POS = 3;
	localparam int EXT_IRQ_B_TRIGGER_SEL_POS = 2;
	localparam int EXT_IRQ_A_EDGE_FLAG_POS = 1;
	localparam int EXT_IRQ_A_TRIGGER_SEL_POS = 0;

	// ****************************************
	// Field positions in timer_mode_select, per timer nibble
	// ****************************************
	localparam int SECOND_NIBBLE_POS = 4;
	localparam int FIRST_NIBBLE_POS = 0;
	localparam int GATING_BIT_POS = 3;
	localparam int COUNT_SOURCE_SEL_POS = 2;
	localparam int MODE_FIELD_POS = 0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int TIMER_TICK_SYS_CYCLES = 2;
	localparam int PRESCALE_BITS = 5;

	typedef enum logic [1:0]
	{
		DTC_MODE_PRESCALED = 2'b00,
		DTC_MODE_WIDE = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_t;

endpackage

//--- core/dtc_evt_if.sv
`timescale 1ns/1ns
// ****************************************
// Synchronised pin events between top and edge detector
// ****************************************
interface dtc_evt_if;
	logic [3:0] pin_level;
	logic [3:0] pin_fall;

	modport detector
	(
		output pin_level,
		output pin_fall
	);

	modport user
	(
		input pin_level,
		input pin_fall
	);
endinterface

//--- core/dtc_edge_detect.sv
`timescale 1ns/1ns
// ****************************************
// Pin synchroniser and falling-edge detector
// ****************************************
module dtc_edge_detect
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// Raw pins
	input wire logic [3:0] i_pins,
	// Events out
	dtc_evt_if.detector evt
);
	logic [3:0] meta_q;
	logic [3:0] meta_d;
	logic [3:0] sync_q;
	logic [3:0] sync_d;
	logic [3:0] last_q;
	logic [3:0] last_d;

	// The first stage feeds only the second; edges are taken from the later stages.
	always_comb
	begin
		meta_d = i_pins;
		sync_d = meta_q;
		last_d = sync_q;
	end

	// Pins reset high so that release does not fake a falling edge.
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_q <= 4'hF;
			sync_q <= 4'hF;
			last_q <= 4'hF;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	assign evt.pin_level = sync_q;
	assign evt.pin_fall = last_q & ~sync_q;
endmodule

//--- core/dtc_tick_div.sv
`timescale 1ns/1ns
// ****************************************
// Divider producing the timer-mode increment enable
// ****************************************
module dtc_tick_div
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// Enable pulse out
	output logic o_tick
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb
	begin
		if (cnt_q == 2'(dtc_pkg::TIMER_TICK_SYS_CYCLES - 1))
		begin
			cnt_d = 2'h0;
			tick_d = 1'b1;
		end
		else
		begin
			cnt_d = cnt_q + 2'h1;
			tick_d = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cnt_q <= 2'h0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign o_tick = tick_q;
endmodule

//--- core/dtc_timer_top.sv
`timescale 1ns/1ns
// Operation
// - The second overflow flag sets on its timer's overflow and clears when the CPU vectors.
// - The first overflow flag sets on its timer's overflow and clears when the CPU vectors.
// - A timer counts only while its run bit (bit 6 or bit 4) is 1 and holds otherwise.
// - Each external edge flag sets on a falling pin edge and clears when the CPU vectors.
// - Each trigger select picks low level when 0 and falling edge when 1.
// - With gating set a timer counts only while its interrupt pin is high and run is set.
// - Timer mode counts once every 2 clocks; counter mode counts each count pin falling edge.
// - Mode 00 is an 8-bit high byte behind a 5-bit prescaler in the low byte.
// - Mode 01 joins high and low bytes into one 16-bit counter.
// - Mode 10 is an 8-bit low byte reloaded from the high byte on overflow.
// - Mode 11 stops the second timer.
// - Mode 11 splits the first timer; its high byte uses the second run bit and flag.
// - The four count bytes are read/write and reset to 00h.
// - The second timer's mode 10 overflow is offered to the serial port as a baud clock.
module dtc_timer_top
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// Special function register bus
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// Interrupt vector acknowledges from the CPU
	input wire logic i_ack_ext_irq_a,
	input wire logic i_ack_first_timer,
	input wire logic i_ack_ext_irq_b,
	input wire logic i_ack_second_timer,
	// Pins
	input wire logic i_ext_irq_a_pin,
	input wire logic i_ext_irq_b_pin,
	input wire logic i_first_count_pin,
	input wire logic i_second_count_pin,
	// Interrupt requests and baud source
	output logic o_ext_irq_a_req,
	output logic o_ext_irq_b_req,
	output logic o_first_timer_req,
	output logic o_second_timer_req,
	output logic o_baud_tick
);
	// ****************************************
	// Pin events
	// ****************************************
	dtc_evt_if evt ();
	logic tick;

	dtc_edge_detect u_edge
	(
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_pins({i_second_count_pin, i_first_count_pin, i_ext_irq_b_pin, i_ext_irq_a_pin}),
		.evt(evt.detector)
	);

	dtc_tick_div u_div
	(
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.o_tick(tick)
	);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [7:0] low_q [2];
	logic [7:0] low_d [2];
	logic [7:0] high_q [2];
	logic [7:0] high_d [2];
	logic [7:0] rdata_d;
	logic [3:0] req_d;
	logic [3:0] req_q;
	logic baud_d;
	logic baud_q;

	// Per-timer increment and overflow terms, index 0 first timer, 1 second timer.
	logic [1:0] inc;
	logic [1:0] run;
	logic [1:0] low_ovf;
	logic [1:0] ovf;
	logic split_high_inc;
	logic split_high_ovf;
	logic [1:0] wr_low;
	logic [1:0] wr_high;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_tmr
			localparam int NIB = (g == 0) ? dtc_pkg::FIRST_NIBBLE_POS :
				dtc_pkg::SECOND_NIBBLE_POS;
			localparam int RUNP = (g == 0) ? dtc_pkg::FIRST_RUN_BIT_POS :
				dtc_pkg::SECOND_RUN_BIT_POS;
			logic gate;
			logic src;
			logic [1:0] md;
			assign gate = mode_q[NIB + dtc_pkg::GATING_BIT_POS];
			assign src = mode_q[NIB + dtc_pkg::COUNT_SOURCE_SEL_POS];
			assign md = mode_q[NIB + dtc_pkg::MODE_FIELD_POS +: 2];
			// Gating reads interrupt pin g, which is pin_level bit g.
			assign run[g] = ctrl_q[RUNP] & (~gate | evt.pin_level[g]);
			// Second timer in mode 11 never counts.
			assign inc[g] = run[g] & (src ? evt.pin_fall[g + 2] : tick) &
				~(g == 1 && md == dtc_pkg::DTC_MODE_SPLIT);
			assign wr_low[g] = i_sfr_wr && i_sfr_addr ==
				((g == 0) ? dtc_pkg::FIRST_COUNT_LOW_ADDR : dtc_pkg::SECOND_COUNT_LOW_ADDR);
			assign wr_high[g] = i_sfr_wr && i_sfr_addr ==
				((g == 0) ? dtc_pkg::FIRST_COUNT_HIGH_ADDR : dtc_pkg::SECOND_COUNT_HIGH_ADDR);

			// ****************************************
			// Counting stages
			// ****************************************
			always_comb
			begin
				low_d[g] = low_q[g];
				high_d[g] = high_q[g];
				low_ovf[g] = 1'b0;
				ovf[g] = 1'b0;
				if (inc[g])
				begin
					case (md)
						dtc_pkg::DTC_MODE_PRESCALED:
						begin
							low_d[g] = {3'h0, low_q[g][4:0] + 5'h01};
							if (low_q[g][4:0] == 5'h1F)
							begin
								high_d[g] = high_q[g] + 8'h01;
								ovf[g] = (high_q[g] == 8'hFF);
							end
						end
						dtc_pkg::DTC_MODE_WIDE:
						begin
							{high_d[g], low_d[g]} = {high_q[g], low_q[g]} + 16'h0001;
							ovf[g] = ({high_q[g], low_q[g]} == 16'hFFFF);
						end
						dtc_pkg::DTC_MODE_RELOAD:
						begin
							low_d[g] = (low_q[g] == 8'hFF) ? high_q[g] : low_q[g] + 8'h01;
							ovf[g] = (low_q[g] == 8'hFF);
						end
						default:
						begin
							low_d[g] = low_q[g] + 8'h01;
							low_ovf[g] = (low_q[g] == 8'hFF);
							ovf[g] = low_ovf[g];
						end
					endcase
				end
				// Split mode: first timer high byte runs on second run bit, timer clock.
				if (g == 0 && split_high_inc)
				begin
					high_d[g] = high_q[g] + 8'h01;
				end
				if (wr_low[g])
				begin
					low_d[g] = i_sfr_wdata;
				end
				if (wr_high[g])
				begin
					high_d[g] = i_sfr_wdata;
				end
			end

			always_ff @(posedge i_ref_clk or negedge i_rstn)
			begin
				if (!i_rstn)
				begin
					low_q[g] <= dtc_pkg::COUNT_RESET;
					high_q[g] <= dtc_pkg::COUNT_RESET;
				end
				else
				begin
					low_q[g] <= low_d[g];
					high_q[g] <= high_d[g];
				end
			end
		end
	endgenerate

	assign split_high_inc = (mode_q[1:0] == dtc_pkg::DTC_MODE_SPLIT) &&
		ctrl_q[dtc_pkg::SECOND_RUN_BIT_POS] && tick;
	assign split_high_ovf = split_high_inc && high_q[0] == 8'hFF;

	// ****************************************
	// Control, flags and read path
	// ****************************************
	always_comb
	begin
		ctrl_d = ctrl_q;
		mode_d = mode_q;
		if (i_sfr_wr && i_sfr_addr == dtc_pkg::TIMER_CONTROL_FLAGS_ADDR)
		begin
			ctrl_d = i_sfr_wdata;
		end
		if (i_sfr_wr && i_sfr_addr == dtc_pkg::TIMER_MODE_SELECT_ADDR)
		begin
			mode_d = i_sfr_wdata;
		end
		// Vectoring clears first; a same-cycle hardware event then wins.
		if (i_ack_first_timer)
		begin
			ctrl_d[dtc_pkg::FIRST_OVERFLOW_FLAG_POS] = 1'b0;
		end
		if (i_ack_second_timer)
		begin
			ctrl_d[dtc_pkg::SECOND_OVERFLOW_FLAG_POS] = 1'b0;
		end
		if (i_ack_ext_irq_a)
		begin
			ctrl_d[dtc_pkg::EXT_IRQ_A_EDGE_FLAG_POS] = 1'b0;
		end
		if (i_ack_ext_irq_b)
		begin
			ctrl_d[dtc_pkg::EXT_IRQ_B_EDGE_FLAG_POS] = 1'b0;
		end
		if (ovf[0])
		begin
			ctrl_d[dtc_pkg::FIRST_OVERFLOW_FLAG_POS] = 1'b1;
		end
		// In split mode the second flag belongs to the first timer's high byte.
		if ((mode_q[1:0] == dtc_pkg::DTC_MODE_SPLIT) ? split_high_ovf : ovf[1])
		begin
			ctrl_d[dtc_pkg::SECOND_OVERFLOW_FLAG_POS] = 1'b1;
		end
		if (evt.pin_fall[0])
		begin
			ctrl_d[dtc_pkg::EXT_IRQ_A_EDGE_FLAG_POS] = 1'b1;
		end
		if (evt.pin_fall[1])
		begin
			ctrl_d[dtc_pkg::EXT_IRQ_B_EDGE_FLAG_POS] = 1'b1;
		end

		case (i_sfr_addr)
			dtc_pkg::TIMER_CONTROL_FLAGS_ADDR: rdata_d = ctrl_q;
			dtc_pkg::TIMER_MODE_SELECT_ADDR: rdata_d = mode_q;
			dtc_pkg::FIRST_COUNT_LOW_ADDR: rdata_d = low_q[0];
			dtc_pkg::SECOND_COUNT_LOW_ADDR: rdata_d = low_q[1];
			dtc_pkg::FIRST_COUNT_HIGH_ADDR: rdata_d = high_q[0];
			dtc_pkg::SECOND_COUNT_HIGH_ADDR: rdata_d = high_q[1];
			default: rdata_d = 8'h00;
		endcase

		// Low-level trigger requests while the pin is low; edge mode uses the flag.
		req_d[0] = ctrl_q[dtc_pkg::EXT_IRQ_A_TRIGGER_SEL_POS] ?
			ctrl_q[dtc_pkg::EXT_IRQ_A_EDGE_FLAG_POS] : ~evt.pin_level[0];
		req_d[1] = ctrl_q[dtc_pkg::EXT_IRQ_B_TRIGGER_SEL_POS] ?
			ctrl_q[dtc_pkg::EXT_IRQ_B_EDGE_FLAG_POS] : ~evt.pin_level[1];
		req_d[2] = ctrl_q[dtc_pkg::FIRST_OVERFLOW_FLAG_POS];
		req_d[3] = ctrl_q[dtc_pkg::SECOND_OVERFLOW_FLAG_POS];
		baud_d = ovf[1] && mode_q[5:4] == dtc_pkg::DTC_MODE_RELOAD;
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ctrl_q <= dtc_pkg::CONTROL_RESET;
			mode_q <= dtc_pkg::MODE_RESET;
			o_sfr_rdata <= 8'h00;
			req_q <= 4'h0;
			baud_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			mode_q <= mode_d;
			o_sfr_rdata <= rdata_d;
			req_q <= req_d;
			baud_q <= baud_d;
		end
	end

	always_comb
	begin
		o_ext_irq_a_req = req_q[0];
		o_ext_irq_b_req = req_q[1];
		o_first_timer_req = req_q[2];
		o_second_timer_req = req_q[3];
		o_baud_tick = baud_q;
	end
endmodule

//--- dv/dtc_timer_sva.sv
`timescale 1ns/1ns
// ****************************************
// Port-level checks on the timer block
// ****************************************
module dtc_timer_sva
(
	// Clock and reset
	input logic i_ref_clk,
	input logic i_rstn,
	// Register bus
	input logic [7:0] i_sfr_addr,
	input logic i_sfr_wr,
	input logic [7:0] i_sfr_wdata,
	input logic [7:0] o_sfr_rdata,
	// Acknowledges and requests
	input logic i_ack_first_timer,
	input logic i_ack_second_timer,
	input logic o_ext_irq_a_req,
	input logic o_ext_irq_b_req,
	input logic o_first_timer_req,
	input logic o_second_timer_req,
	input logic o_baud_tick
);
	// The second flag goes to the first timer's high byte while that timer is split.
	logic split_q;
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			split_q <= 1'b0;
		end
		else if (i_sfr_wr && i_sfr_addr == 8'h89)
		begin
			split_q <= i_sfr_wdata[1:0] == 2'h3;
		end
	end

	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);

	map_rd_a: assert property (!(i_sfr_addr inside {[8'h88:8'h8D]}) |=> o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	wr_rd_a: assert property (i_sfr_wr && i_sfr_addr inside {[8'h89:8'h8D]} ##1 $stable(i_sfr_addr)
		|=> o_sfr_rdata == $past(i_sfr_wdata, 2))
		else $error("written byte not read back");
	rst_clr_a: assert property ($rose(i_rstn) |-> o_sfr_rdata == 8'h00 && !o_baud_tick
		&& !o_first_timer_req && !o_second_timer_req && !o_ext_irq_a_req && !o_ext_irq_b_req)
		else $error("outputs not clear after reset");
	baud_one_a: assert property (o_baud_tick |=> !o_baud_tick)
		else $error("baud pulse too long");
	baud_flag_a: assert property (o_baud_tick && !$past(split_q) |=> o_second_timer_req)
		else $error("baud pulse without second flag");
	first_flag_fall_a: assert property ($fell(o_first_timer_req) |-> $past(i_ack_first_timer, 2)
		|| $past(i_sfr_wr, 2))
		else $error("first flag cleared without cause");
	second_flag_fall_a: assert property ($fell(o_second_timer_req) |-> $past(i_ack_second_timer, 2)
		|| $past(i_sfr_wr, 2))
		else $error("second flag cleared without cause");
	flag_rd_a: assert property ($past(i_sfr_addr) == 8'h88 |-> o_sfr_rdata[7] == o_second_timer_req
		&& o_sfr_rdata[5] == o_first_timer_req)
		else $error("read flags differ from requests");
endmodule

bind dtc_timer_top dtc_timer_sva u_dtc_timer_sva (.i_ref_clk, .i_rstn, .i_sfr_addr, .i_sfr_wr,
	.i_sfr_wdata, .o_sfr_rdata, .i_ack_first_timer, .i_ack_second_timer, .o_ext_irq_a_req,
	.o_ext_irq_b_req, .o_first_timer_req, .o_second_timer_req, .o_baud_tick);

//--- dv/dtc_cpu_model.sv
`timescale 1ns/1ns
// ****************************************
// CPU that vectors into enabled service routines
// ****************************************
module dtc_cpu_model
(
	// Clock and reset
	input logic i_ref_clk,
	input logic i_rstn,
	// Requests and vector enables
	input logic [3:0] i_req,
	input logic [3:0] i_en,
	// Vector acknowledges
	output logic [3:0] o_ack
);
	// A request lags its flag, so the model waits before it may vector again.
	int gap;
	always @(negedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_ack <= 4'h0;
			gap <= 0;
		end
		else if (gap != 0)
		begin
			o_ack <= 4'h0;
			gap <= gap - 1;
		end
		else
		begin
			o_ack <= i_req & i_en;
			gap <= (|(i_req & i_en)) ? 4 : 0;
		end
	end
endmodule

//--- dv/tb.sv
`timescale 1ns/1ns
module tb;
	logic i_ref_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_sfr_addr = 8'h00;
	logic i_sfr_wr = 1'b0;
	logic [7:0] i_sfr_wdata = 8'h00;
	logic [7:0] o_sfr_rdata;
	logic o_baud_tick;
	logic [3:0] ack;
	logic [3:0] req;
	logic [3:0] en = 4'h0;
	logic [3:0] pin = 4'hF;
	int failures = 0;
	int cmp_count = 0;
	int bauds = 0;

	always #2 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk)
		if (o_baud_tick === 1'b1)
			bauds++;

	dtc_timer_top u_dtc_timer_top
	(
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
		.i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_ack_ext_irq_a(ack[0]),
		.i_ack_first_timer(ack[1]), .i_ack_ext_irq_b(ack[2]), .i_ack_second_timer(ack[3]),
		.i_ext_irq_a_pin(pin[0]), .i_ext_irq_b_pin(pin[1]), .i_first_count_pin(pin[2]),
		.i_second_count_pin(pin[3]), .o_ext_irq_a_req(req[0]), .o_ext_irq_b_req(req[2]),
		.o_first_timer_req(req[1]), .o_second_timer_req(req[3]), .o_baud_tick(o_baud_tick)
	);
	dtc_cpu_model u_dtc_cpu_model
	(
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_req(req), .i_en(en), .o_ack(ack)
	);

	task summarize;
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		i_sfr_addr = a;
		i_sfr_wr = 1'b1;
		i_sfr_wdata = d;
		@(negedge i_ref_clk);
		i_sfr_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_ref_clk);
		i_sfr_addr = a;
		@(negedge i_ref_clk);
		chk($sformatf("reg_%h", a), o_sfr_rdata, e);
	endtask
	// ****************************************
	// Start and stop writes land exactly 20 edges apart, which is 10 timer ticks.
	// ****************************************
	// The stop write may itself set flags, so the hardware-set timer requests are checked first.
	task run(input logic [7:0] on, input logic [7:0] off, input logic [7:0] er);
		wr(8'h88, on);
		repeat (18) @(negedge i_ref_clk);
		chk("timer_req", {4'h0, req & 4'hA}, er);
		wr(8'h88, off);
	endtask
	task tm(input logic [7:0] md, tl, th, on, off, etl, eth, er);
		wr(8'h89, md);
		wr(8'h8A, tl);
		wr(8'h8C, th);
		run(on, off, er);
		rd(8'h8A, etl);
		rd(8'h8C, eth);
	endtask
	task vec(input int b);
		@(negedge i_ref_clk);
		en[b] <= 1'b1;
		repeat (6) @(negedge i_ref_clk);
		en <= 4'h0;
	endtask

	initial
	begin
		repeat (3) @(negedge i_ref_clk);
		i_rstn = 1'b1;
		for (int a = 8'h88; a < 8'h8F; a++)
			rd(8'(a), 8'h00);
		for (int a = 8'h89; a < 8'h8E; a++)
		begin
			wr(8'(a), 8'(a) ^ 8'h5A);
			rd(8'(a), 8'(a) ^ 8'h5A);
		end
		tm(8'h01, 8'hF8, 8'h00, 8'h10, 8'h00, 8'h02, 8'h01, 8'h00);
		tm(8'h00, 8'h1E, 8'h00, 8'h10, 8'h00, 8'h08, 8'h01, 8'h00);
		tm(8'h02, 8'hFC, 8'hF0, 8'h10, 8'h20, 8'hF6, 8'hF0, 8'h02);
		rd(8'h88, 8'h20);
		vec(1);
		rd(8'h88, 8'h00);
		pin[0] = 1'b0;
		tm(8'h09, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00);
		pin[0] = 1'b1;
		tm(8'h09, 8'h00, 8'h00, 8'h10, 8'h00, 8'h0A, 8'h00, 8'h00);
		tm(8'h33, 8'h00, 8'hFC, 8'h50, 8'h80, 8'h0A, 8'h06, 8'h08);
		rd(8'h8B, 8'hD1);
		rd(8'h88, 8'h80);
		vec(3);
		rd(8'h88, 8'h00);
		wr(8'h8D, 8'hFE);
		wr(8'h8B, 8'hFE);
		wr(8'h89, 8'h20);
		bauds = 0;
		run(8'h40, 8'h80, 8'h08);
		repeat (4) @(negedge i_ref_clk);
		chk("bauds", 8'(bauds), 8'h05);
		rd(8'h88, 8'h80);
		wr(8'h89, 8'h05);
		wr(8'h8A, 8'h00);
		wr(8'h8C, 8'h00);
		wr(8'h88, 8'h10);
		repeat (5)
		begin
			pin[2] = 1'b0;
			repeat (3) @(negedge i_ref_clk);
			pin[2] = 1'b1;
			repeat (3) @(negedge i_ref_clk);
		end
		repeat (4) @(negedge i_ref_clk);
		wr(8'h88, 8'h05);
		rd(8'h8A, 8'h05);
		pin[0] = 1'b0;
		repeat (8) @(negedge i_ref_clk);
		pin[0] = 1'b1;
		repeat (8) @(negedge i_ref_clk);
		chk("irq_a", {7'h00, req[0]}, 8'h01);
		rd(8'h88, 8'h07);
		vec(0);
		rd(8'h88, 8'h05);
		wr(8'h88, 8'h00);
		pin[1] = 1'b0;
		repeat (6) @(negedge i_ref_clk);
		chk("irq_b", {7'h00, req[2]}, 8'h01);
		pin[1] = 1'b1;
		repeat (6) @(negedge i_ref_clk);
		chk("irq_b", {7'h00, req[2]}, 8'h00);
		i_rstn = 1'b0;
		@(negedge i_ref_clk);
		i_rstn = 1'b1;
		rd(8'h8A, 8'h00);
		summarize();
	end

	initial
	begin
		#100000;
		failures++;
		summarize();
	end
endmodule
